// ### rtl/ctnc_mask_decode.sv
// Purpose: expands a prefix length into a 32-bit subnet mask
// Assumes: prefix 1..31; 0 is reserved and yields an all-zero mask
// Notes:   combinational, one generate loop over the mask bits
`timescale 1ns/1ns
module ctnc_mask_decode
	import ctnc_pkg::*;
(
	input  wire logic [4:0]  prefixLen, // leading ones count
	output logic      [31:0] subnetMask // decoded mask
);
	// ====================================================================
	// bit i (from msb) is one when its position is below the prefix
	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_bit
			assign subnetMask[31 - i] = (6'(i) < {1'b0, prefixLen});
		end
	endgenerate
endmodule

// ### rtl/ctnc_pkg.sv
// Purpose: shared constants for the comm timeout and fieldbus config block
// Assumes: 32-bit classic Wishbone, 100 MHz core clock
// Notes:   offsets are byte addresses of aligned words
package ctnc_pkg;
	// ====================================================================
	// register offsets
	localparam logic [7:0] CTNC_OFS_TMO_CFG  = 8'h00; // mode, action, time
	localparam logic [7:0] CTNC_OFS_TMO_STAT = 8'h04; // timeout status
	localparam logic [7:0] CTNC_OFS_FB_CFG   = 8'h08; // node, rate, source
	localparam logic [7:0] CTNC_OFS_FB_CTRL  = 8'h0c; // reinit request
	localparam logic [7:0] CTNC_OFS_IP_ADDR  = 8'h10; // programmed ip
	localparam logic [7:0] CTNC_OFS_PREFIX   = 8'h14; // prefix length
	localparam logic [7:0] CTNC_OFS_ACT_IP   = 8'h18; // applied ip
	localparam logic [7:0] CTNC_OFS_ACT_MASK = 8'h1c; // applied mask
	localparam logic [7:0] CTNC_OFS_ACT_FB   = 8'h20; // applied fb settings
	// ====================================================================
	// field positions
	localparam int CTNC_POS_MODE   = 0;  // [1:0] trip mode
	localparam int CTNC_POS_ACTION = 4;  // [6:4] alarm action
	localparam int CTNC_POS_TIME   = 16; // [29:16] silent time, 0.1 s
	localparam int CTNC_POS_NODE   = 0;  // [7:0] node address
	localparam int CTNC_POS_RATE   = 8;  // [9:8] bit rate
	localparam int CTNC_POS_SRC    = 12; // [13:12] ip source
	// ====================================================================
	// reset values
	localparam logic [1:0]  CTNC_RST_MODE   = 2'h2;
	localparam logic [2:0]  CTNC_RST_ACTION = 3'h2;
	localparam logic [13:0] CTNC_RST_TIME   = 14'h0000;
	localparam logic [7:0]  CTNC_RST_NODE   = 8'h3f;
	localparam logic [1:0]  CTNC_RST_RATE   = 2'h3;
	localparam logic [1:0]  CTNC_RST_SRC    = 2'h1;
	localparam logic [31:0] CTNC_RST_IP     = 32'hc0a8000a;
	localparam logic [4:0]  CTNC_RST_PREFIX = 5'h18;
	localparam logic [13:0] CTNC_TIME_MAX   = 14'h270f; // 999.9 s
	localparam logic [2:0]  CTNC_ACTION_MAX = 3'h4;
	// ====================================================================
	// timing: one silent-time step is 0.1 s
	localparam int CTNC_STEP_MS     = 100;
	localparam int CTNC_CLK_MHZ     = 100;
	localparam int CTNC_STEP_CYCLES = CTNC_STEP_MS * 1000 * CTNC_CLK_MHZ;
	localparam int CTNC_REINIT_US   = 10;
	localparam int CTNC_REINIT_CYC  = CTNC_REINIT_US * CTNC_CLK_MHZ;
	// ====================================================================
	// encodings
	typedef enum logic [1:0] {
		CTNC_TRIP_NONE  = 2'h0,
		CTNC_TRIP_FAULT = 2'h1,
		CTNC_TRIP_ALARM = 2'h2
	} ctnc_trip_type;
	typedef enum logic [2:0] {
		CTNC_ACT_INDICATE = 3'h0,
		CTNC_ACT_RAMPSTOP = 3'h1,
		CTNC_ACT_DISABLE  = 3'h2,
		CTNC_ACT_LOCAL    = 3'h3,
		CTNC_ACT_REMOTE   = 3'h4
	} ctnc_action_type;
	localparam logic [1:0] CTNC_SRC_LOCAL = 2'h0;
	localparam logic [1:0] CTNC_RATE_AUTO = 2'h3;
	// control word bits
	localparam int CTNC_CW_RAMPSTOP = 0;
	localparam int CTNC_CW_DISABLE  = 1;
	localparam int CTNC_CW_LOCAL    = 2;
	localparam int CTNC_CW_REMOTE   = 3;
endpackage

// ### rtl/ctnc_silence_timer.sv
// Purpose: serial-link silence timer in 0.1 s steps
// Assumes: telegramOk is a one-cycle pulse on core_clk
// Notes:   arms on first valid telegram; limit 0 disables
`timescale 1ns/1ns
module ctnc_silence_timer
	import ctnc_pkg::*;
#(
	parameter int STEP_CYCLES = CTNC_STEP_CYCLES // cycles per 0.1 s
) (
	input  wire logic        core_clk,   // clock
	input  wire logic        rst,        // sync reset
	input  wire logic        telegramOk, // valid telegram pulse
	input  wire logic [13:0] limit,      // silent time, 0.1 s units
	output logic             expired     // silence exceeded, level
);
	logic        armed_reg;
	logic [31:0] prescale_reg;
	logic [13:0] steps_reg;
	logic        tick;

	// ====================================================================
	// timer arms on the first telegram
	always_ff @(posedge core_clk) begin
		if (rst)
			armed_reg <= 1'b0;
		else if (telegramOk)
			armed_reg <= 1'b1;
	end

	// step prescaler restarts with every telegram
	assign tick = (prescale_reg == 32'(STEP_CYCLES - 1));
	always_ff @(posedge core_clk) begin
		if (rst || telegramOk || !armed_reg)
			prescale_reg <= 32'h0;
		else if (tick)
			prescale_reg <= 32'h0;
		else
			prescale_reg <= prescale_reg + 32'h1;
	end

	// step counter saturates one past the limit
	always_ff @(posedge core_clk) begin
		if (rst || telegramOk || !armed_reg)
			steps_reg <= 14'h0;
		else if (tick && steps_reg <= limit)
			steps_reg <= steps_reg + 14'h1;
	end

	// longer than the limit, and never with limit zero
	assign expired = armed_reg && (limit != 14'h0) && (steps_reg > limit);
endmodule

// ### rtl/ctnc_top.sv
// Purpose: comm timeout supervision and fieldbus config register bank
// Assumes: classic Wishbone slave, 32-bit data, one clock, sync reset
// Notes:   applied fieldbus settings change only on reinit, except fbRateUsed, which tracks isDevicenet every cycle
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module ctnc_top
	import ctnc_pkg::*;
#(
	parameter int STEP_CYCLES   = CTNC_STEP_CYCLES, // cycles per 0.1 s
	parameter int REINIT_CYCLES = CTNC_REINIT_CYC   // reinit duration
) (
	input  wire logic        core_clk,     // 100 MHz clock
	input  wire logic        rst,          // sync reset, active high
	input  wire logic        wb_cyc_i,     // wishbone cycle
	input  wire logic        wb_stb_i,     // wishbone strobe
	input  wire logic        wb_we_i,      // wishbone write enable
	input  wire logic [7:0]  wb_adr_i,     // byte address
	input  wire logic [3:0]  wb_sel_i,     // byte lanes
	input  wire logic [31:0] wb_dat_i,     // write data
	output logic      [31:0] wb_dat_o,     // read data
	output logic             wb_ack_o,     // acknowledge
	input  wire logic        telegramOk,   // valid serial telegram pulse
	input  wire logic        motorStopped, // motor at standstill
	input  wire logic        isDevicenet,  // fitted module type
	output logic             serial_timeout_fault, // fault, level
	output logic             serial_timeout_alarm, // alarm, level
	output logic             motorDisable, // disable motor
	output logic      [3:0]  slotCtrlWord, // serial slot command bits
	output logic             fbReinit,     // module in reinit
	output logic      [7:0]  fbNode,       // applied node address
	output logic      [1:0]  fbRate,       // applied bit rate
	output logic             fbRateUsed,   // rate valid for module
	output logic      [1:0]  ipSource,     // applied ip source
	output logic      [31:0] ipAddr,       // applied ip, 0 unless local
	output logic      [31:0] ipMask        // applied mask, 0 unless local
);
	// settings
	logic [1:0]  timeout_trip_mode_reg;
	logic [2:0]  timeout_alarm_action_reg;
	logic [13:0] timeout_silent_time_reg;
	logic [7:0]  fieldbus_node_address_reg;
	logic [1:0]  fieldbus_bit_rate_reg;
	logic [1:0]  ip_source_select_reg;
	logic [31:0] ip_addr_setting_reg;
	logic [4:0]  prefix_length_setting_reg;
	logic        fieldbus_reinit_request_reg;
	logic [31:0] reinitCnt_reg;
	logic        telegramSeen_reg;
	logic        reinitDone;
	logic        expired;
	logic [31:0] maskDecoded;
	logic        wbReq;
	logic        wrTake;
	logic [31:0] rdData;
	logic [13:0] timeWr;
	logic [2:0]  actWr;

	// ====================================================================
	// bus access: one wait cycle, ack high for one cycle
	assign wbReq  = wb_cyc_i && wb_stb_i;
	assign wrTake = wbReq && wb_we_i && !wb_ack_o;
	always_ff @(posedge core_clk) begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq && !wb_ack_o;
	end

	// write time clamped to its maximum; an out-of-range action keeps the old value
	assign timeWr = (wb_dat_i[CTNC_POS_TIME +: 14] > CTNC_TIME_MAX) ?
		CTNC_TIME_MAX : wb_dat_i[CTNC_POS_TIME +: 14];
	assign actWr = (wb_dat_i[CTNC_POS_ACTION +: 3] > CTNC_ACTION_MAX) ?
		timeout_alarm_action_reg : wb_dat_i[CTNC_POS_ACTION +: 3];

	// ====================================================================
	// timeout configuration register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timeout_trip_mode_reg    <= CTNC_RST_MODE;
			timeout_alarm_action_reg <= CTNC_RST_ACTION;
			timeout_silent_time_reg  <= CTNC_RST_TIME;
		end else if (wrTake && wb_adr_i == CTNC_OFS_TMO_CFG) begin
			if (wb_sel_i[0]) begin
				if (wb_dat_i[CTNC_POS_MODE +: 2] != 2'h3)
					timeout_trip_mode_reg <= wb_dat_i[CTNC_POS_MODE +: 2];
				timeout_alarm_action_reg <= actWr;
			end
			if (wb_sel_i[2] && wb_sel_i[3])
				timeout_silent_time_reg <= timeWr;
		end
	end

	// fieldbus configuration, stored but not yet applied
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fieldbus_node_address_reg <= CTNC_RST_NODE;
			fieldbus_bit_rate_reg     <= CTNC_RST_RATE;
			ip_source_select_reg      <= CTNC_RST_SRC;
		end else if (wrTake && wb_adr_i == CTNC_OFS_FB_CFG) begin
			if (wb_sel_i[0])
				fieldbus_node_address_reg <= wb_dat_i[CTNC_POS_NODE +: 8];
			if (wb_sel_i[1]) begin
				fieldbus_bit_rate_reg <= wb_dat_i[CTNC_POS_RATE +: 2];
				if (wb_dat_i[CTNC_POS_SRC +: 2] != 2'h3)
					ip_source_select_reg <= wb_dat_i[CTNC_POS_SRC +: 2];
			end
		end
	end

	// ip address and prefix settings
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_iplane
			always_ff @(posedge core_clk) begin
				if (rst)
					ip_addr_setting_reg[8*b +: 8] <= CTNC_RST_IP[8*b +: 8];
				else if (wrTake && wb_adr_i == CTNC_OFS_IP_ADDR && wb_sel_i[b])
					ip_addr_setting_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
		end
	endgenerate

	// prefix 0 is reserved and refused
	always_ff @(posedge core_clk) begin
		if (rst)
			prefix_length_setting_reg <= CTNC_RST_PREFIX;
		else if (wrTake && wb_adr_i == CTNC_OFS_PREFIX && wb_sel_i[0]
			&& wb_dat_i[4:0] != 5'h0 && wb_dat_i[7:5] == 3'h0)
			prefix_length_setting_reg <= wb_dat_i[4:0];
	end

	// ====================================================================
	// reinit request: accepted only while stopped, clears when done
	assign reinitDone = (reinitCnt_reg == 32'(REINIT_CYCLES - 1));
	always_ff @(posedge core_clk) begin
		if (rst)
			fieldbus_reinit_request_reg <= 1'b0;
		else if (wrTake && wb_adr_i == CTNC_OFS_FB_CTRL && wb_sel_i[0]
			&& wb_dat_i[0] && motorStopped && !fieldbus_reinit_request_reg)
			fieldbus_reinit_request_reg <= 1'b1;
		else if (reinitDone)
			fieldbus_reinit_request_reg <= 1'b0;
	end

	// reinit duration counter
	always_ff @(posedge core_clk) begin
		if (rst || !fieldbus_reinit_request_reg || reinitDone)
			reinitCnt_reg <= 32'h0;
		else
			reinitCnt_reg <= reinitCnt_reg + 32'h1;
	end

	// comms held off during reinit
	always_ff @(posedge core_clk) begin
		if (rst)
			fbReinit <= 1'b0;
		else
			fbReinit <= fieldbus_reinit_request_reg;
	end

	// applied settings latch at end of reinit (or reset = power up); fbRateUsed follows isDevicenet every cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fbNode     <= CTNC_RST_NODE;
			fbRate     <= CTNC_RST_RATE;
			fbRateUsed <= 1'b0;
			ipSource   <= CTNC_RST_SRC;
			ipAddr     <= 32'h0;
			ipMask     <= 32'h0;
		end else begin
			fbRateUsed <= isDevicenet;
			if (reinitDone) begin
				fbNode   <= fieldbus_node_address_reg;
				fbRate   <= fieldbus_bit_rate_reg;
				ipSource <= ip_source_select_reg;
				ipAddr   <= (ip_source_select_reg == CTNC_SRC_LOCAL) ?
					ip_addr_setting_reg : 32'h0;
				ipMask   <= (ip_source_select_reg == CTNC_SRC_LOCAL) ?
					maskDecoded : 32'h0;
			end
		end
	end

	ctnc_mask_decode u_mask (
		.prefixLen  (prefix_length_setting_reg),
		.subnetMask (maskDecoded)
	);

	// ====================================================================
	// serial silence supervision
	ctnc_silence_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_timer (
		.core_clk   (core_clk),
		.rst        (rst),
		.telegramOk (telegramOk),
		.limit      (timeout_silent_time_reg),
		.expired    (expired)
	);

	// first telegram seen, tracked apart from the timer for the checks
	always_ff @(posedge core_clk) begin
		if (rst)
			telegramSeen_reg <= 1'b0;
		else if (telegramOk)
			telegramSeen_reg <= 1'b1;
	end

	// trip outputs follow mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			serial_timeout_fault <= 1'b0;
			serial_timeout_alarm <= 1'b0;
			motorDisable         <= 1'b0;
		end else begin
			serial_timeout_fault <= expired &&
				timeout_trip_mode_reg == CTNC_TRIP_FAULT;
			motorDisable <= expired &&
				timeout_trip_mode_reg == CTNC_TRIP_FAULT;
			serial_timeout_alarm <= expired &&
				timeout_trip_mode_reg == CTNC_TRIP_ALARM;
		end
	end

	// alarm action onto slot command bits
	always_ff @(posedge core_clk) begin
		if (rst)
			slotCtrlWord <= 4'h0;
		else if (expired && timeout_trip_mode_reg == CTNC_TRIP_ALARM) begin
			slotCtrlWord <= 4'h0;
			unique case (timeout_alarm_action_reg)
				CTNC_ACT_RAMPSTOP: slotCtrlWord[CTNC_CW_RAMPSTOP] <= 1'b1;
				CTNC_ACT_DISABLE:  slotCtrlWord[CTNC_CW_DISABLE] <= 1'b1;
				CTNC_ACT_LOCAL:    slotCtrlWord[CTNC_CW_LOCAL] <= 1'b1;
				CTNC_ACT_REMOTE:   slotCtrlWord[CTNC_CW_REMOTE] <= 1'b1;
				default:           slotCtrlWord <= 4'h0;
			endcase
		end else
			slotCtrlWord <= 4'h0;
	end

	// ====================================================================
	// read mux; unmapped reads return zero
	always_comb begin
		rdData = 32'h0;
		unique case (wb_adr_i)
			CTNC_OFS_TMO_CFG: begin
				rdData[CTNC_POS_MODE +: 2]   = timeout_trip_mode_reg;
				rdData[CTNC_POS_ACTION +: 3] = timeout_alarm_action_reg;
				rdData[CTNC_POS_TIME +: 14]  = timeout_silent_time_reg;
			end
			CTNC_OFS_TMO_STAT: rdData[1:0] = {serial_timeout_alarm,
				serial_timeout_fault};
			CTNC_OFS_FB_CFG: begin
				rdData[CTNC_POS_NODE +: 8] = fieldbus_node_address_reg;
				rdData[CTNC_POS_RATE +: 2] = fieldbus_bit_rate_reg;
				rdData[CTNC_POS_SRC +: 2]  = ip_source_select_reg;
			end
			CTNC_OFS_FB_CTRL:  rdData[0] = fieldbus_reinit_request_reg;
			CTNC_OFS_IP_ADDR:  rdData = ip_addr_setting_reg;
			CTNC_OFS_PREFIX:   rdData[4:0] = prefix_length_setting_reg;
			CTNC_OFS_ACT_IP:   rdData = ipAddr;
			CTNC_OFS_ACT_MASK: rdData = ipMask;
			CTNC_OFS_ACT_FB: begin
				rdData[CTNC_POS_NODE +: 8] = fbNode;
				rdData[CTNC_POS_RATE +: 2] = fbRate;
				rdData[CTNC_POS_SRC +: 2]  = ipSource;
			end
			default: rdData = 32'h0;
		endcase
	end

	// read data registered with ack
	always_ff @(posedge core_clk) begin
		if (rst)
			wb_dat_o <= 32'h0;
		else if (wbReq && !wb_ack_o && !wb_we_i)
			wb_dat_o <= rdData;
	end

	// ====================================================================
	// checks
	// trip outputs against the mode and action
	a_fault_mode: assert property (@(posedge core_clk)
		disable iff (rst)
		serial_timeout_fault |-> motorDisable && !serial_timeout_alarm)
		else $error("fault without motor disable");
	a_alarm_gate: assert property (@(posedge core_clk)
		disable iff (rst)
		(slotCtrlWord != 4'h0) |-> $past(timeout_trip_mode_reg) == 2'h2)
		else $error("action outside alarm mode");
	a_action_onehot: assert property (@(posedge core_clk)
		disable iff (rst)
		(serial_timeout_alarm && $past(timeout_alarm_action_reg) != 3'h0)
		|-> $onehot(slotCtrlWord))
		else $error("alarm action not one command bit");
	// silence timer seen through its expired output and the trip outputs
	a_no_trip_zero: assert property (@(posedge core_clk)
		disable iff (rst)
		($past(timeout_silent_time_reg) == 14'h0)
		|-> !serial_timeout_fault && !serial_timeout_alarm)
		else $error("trip with zero silent time");
	a_armed_first: assert property (@(posedge core_clk)
		disable iff (rst)
		$rose(expired) |-> !$past(telegramOk))
		else $error("trip right at telegram");
	a_wait_first: assert property (@(posedge core_clk)
		disable iff (rst)
		!telegramSeen_reg |-> !serial_timeout_fault && !serial_timeout_alarm)
		else $error("trip before first telegram");
	// reinit handshake and applied settings
	a_reinit_gate: assert property (@(posedge core_clk)
		disable iff (rst)
		$rose(fieldbus_reinit_request_reg) |-> $past(motorStopped))
		else $error("reinit while running");
	a_reinit_clear: assert property (@(posedge core_clk)
		disable iff (rst)
		reinitDone |=> !fieldbus_reinit_request_reg)
		else $error("reinit did not self clear");
	a_apply_reinit: assert property (@(posedge core_clk)
		disable iff (rst)
		$changed(fbRate) |-> $past(reinitDone))
		else $error("rate applied without reinit");
	a_apply_hold: assert property (@(posedge core_clk)
		disable iff (rst)
		($changed(fbNode) || $changed(ipSource) || $changed(ipAddr)
		|| $changed(ipMask)) |-> $past(reinitDone))
		else $error("setting applied without reinit");
	a_ip_local: assert property (@(posedge core_clk)
		disable iff (rst)
		(ipSource != 2'h0) |-> ipAddr == 32'h0 && ipMask == 32'h0)
		else $error("ip applied when not local");
	a_prefix_res: assert property (@(posedge core_clk)
		disable iff (rst)
		prefix_length_setting_reg != 5'h0)
		else $error("reserved prefix stored");
endmodule

// ### testbench/ctnc_net_master.sv
// Purpose: serial network master model that sends valid telegrams
// Assumes: a telegram is a one-cycle pulse on the core clock
// Notes:   the model never sends a corrupt telegram, so none is modelled
`timescale 1ns/1ns
module ctnc_net_master (
	input  wire logic core_clk,   // shared clock
	output logic      telegramOk  // valid telegram pulse
);
	// ====================================================================
	// link idles with no telegram until the bench asks for one
	initial telegramOk = 1'b0;
	// the serial slot is taken to be commanded by this link
	// this master owns its own node address on the link
	// it runs at the one bit rate shared by every node
	// one telegram, raised just after an edge and held one cycle
	task automatic send();
		@(posedge core_clk);
		telegramOk <= 1'b1;
		@(posedge core_clk);
		telegramOk <= 1'b0;
	endtask
endmodule

// ### testbench/ctnc_tb_top.sv
// Purpose: self-checking bench for the comm timeout and fieldbus bank
// Assumes: short step and reinit counts set as parameters below
// Notes:   integer model tracks the config registers and the applied node, rate and ip source
`timescale 1ns/1ns
module ctnc_tb_top;
	import ctnc_pkg::*;
	localparam int STEP = 10;
	logic        core_clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
	logic        wbWe = 1'b0, wbAck, telegramOk;
	logic [7:0]  wbAdr = 8'h00, fbNode;
	logic [3:0]  wbSel = 4'hf, slotCtrlWord;
	logic [31:0] wbDatI = 32'h0, wbDatO, ipAddr, ipMask, rnd = 32'hacfc, q;
	logic        motorStopped = 1'b0, isDevicenet = 1'b0, fault, alarm;
	logic        motorDisable, fbReinit, fbRateUsed;
	logic [1:0]  fbRate, ipSource;
	int          error_cnt = 0, total_checks = 0;
	int          mMode = 2, mAct = 2, mTime = 0, mNode, mRate, mSrc;
	int          aNode = 63, aRate = 3, aSrc = 1, mPre = 24;
	logic [31:0] mIp;
	// ====================================================================
	// clock, design and far-side model
	always #5 core_clk = ~core_clk;
	ctnc_top #(.STEP_CYCLES(STEP), .REINIT_CYCLES(4)) dut (
		.core_clk(core_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.telegramOk(telegramOk), .motorStopped(motorStopped),
		.isDevicenet(isDevicenet), .serial_timeout_fault(fault),
		.serial_timeout_alarm(alarm), .motorDisable(motorDisable),
		.slotCtrlWord(slotCtrlWord), .fbReinit(fbReinit), .fbNode(fbNode),
		.fbRate(fbRate), .fbRateUsed(fbRateUsed), .ipSource(ipSource),
		.ipAddr(ipAddr), .ipMask(ipMask));
	ctnc_net_master master (.core_clk(core_clk), .telegramOk(telegramOk));
	// ====================================================================
	// helpers
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (n >= 50) chk("ack", 1, 0);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	// timeout settings through the bus, model applies refusals
	task automatic cfg(int m, int a, int t);
		if (m < 3) mMode = m;
		if (a < 5) mAct = a;
		mTime = (t > 9999) ? 9999 : t;
		wb(1'b1, CTNC_OFS_TMO_CFG, (t << 16) | (a << 4) | m);
	endtask
	task automatic waitRe(logic lvl);
		int n;
		n = 0;
		while (fbReinit !== lvl && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		chk("fbReinit", lvl, fbReinit);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ====================================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		conclude();
	end
	// ====================================================================
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(CTNC_OFS_TMO_CFG, 32'h00000022);
		rd(CTNC_OFS_FB_CFG, 32'h0000133f);
		rd(CTNC_OFS_IP_ADDR, 32'hc0a8000a);
		rd(CTNC_OFS_PREFIX, 32'd24);
		rd(CTNC_OFS_FB_CTRL, 32'h0);
		rd(8'h24, 32'h0);
		chk("ipAddr", 0, ipAddr);
		cfg(1, 0, 3);
		repeat (100) @(posedge core_clk);
		rd(CTNC_OFS_TMO_STAT, 0);
		master.send();
		repeat (30) @(posedge core_clk);
		rd(CTNC_OFS_TMO_STAT, 0);
		repeat (15) @(posedge core_clk);
		rd(CTNC_OFS_TMO_STAT, 1);
		chk("motorDisable", 1, motorDisable);
		chk("ctrl", 0, slotCtrlWord);
		master.send();
		repeat (3) @(posedge core_clk);
		chk("fault", 0, fault);
		for (int m = 0; m < 3; m += 2)
			for (int a = 0; a < 5; a++) begin
				cfg(m, a, 3);
				master.send();
				repeat (50) @(posedge core_clk);
				chk("alarm", m == 2, alarm);
				chk("ctrl", (m == 2 && a > 0) ? 1 << (a - 1) : 0, slotCtrlWord);
				chk("fault", 0, fault);
				rd(CTNC_OFS_TMO_STAT, (m == 2) ? 2 : 0);
			end
		cfg(1, 0, 0);
		master.send();
		repeat (100) @(posedge core_clk);
		chk("fault", 0, fault);
		cfg(3, 5, 10000);
		rd(CTNC_OFS_TMO_CFG, (mTime << 16) | (mAct << 4) | mMode);
		for (int i = 1; i < 32; i++) begin
			rnd = lfsr(rnd);
			mNode = rnd[7:0];
			mRate = i % 4;
			mSrc = i % 3;
			mIp = rnd;
			mPre = i;
			isDevicenet <= rnd[8];
			wb(1'b1, CTNC_OFS_FB_CFG, (mSrc << 12) | (mRate << 8) | mNode);
			wb(1'b1, CTNC_OFS_IP_ADDR, mIp);
			wb(1'b1, CTNC_OFS_PREFIX, mPre);
			chk("fbNode", aNode, fbNode);
			if (i == 1) begin
				motorStopped <= 1'b0;
				wb(1'b1, CTNC_OFS_FB_CTRL, 1);
				repeat (10) @(posedge core_clk);
				chk("fbReinit", 0, fbReinit);
				chk("fbRate", aRate, fbRate);
			end
			motorStopped <= 1'b1;
			wb(1'b1, CTNC_OFS_FB_CTRL, 1);
			waitRe(1'b1);
			waitRe(1'b0);
			rd(CTNC_OFS_FB_CTRL, 0);
			aNode = mNode;
			aRate = mRate;
			aSrc = mSrc;
			chk("fbNode", aNode, fbNode);
			chk("fbRate", aRate, fbRate);
			chk("fbRateUsed", isDevicenet, fbRateUsed);
			chk("ipSource", aSrc, ipSource);
			chk("ipAddr", aSrc == 0 ? mIp : 0, ipAddr);
			chk("ipMask", aSrc == 0 ? 32'hffffffff << (32 - i) : 0, ipMask);
			rd(CTNC_OFS_FB_CFG, (mSrc << 12) | (mRate << 8) | mNode);
			rd(CTNC_OFS_ACT_FB, (aSrc << 12) | (aRate << 8) | aNode);
		end
		wb(1'b1, CTNC_OFS_PREFIX, 0);
		rd(CTNC_OFS_PREFIX, mPre);
		conclude();
	end
endmodule
